// ==== include/cic_pkg.sv ====
// constants, field layout and carrier types for the counter input conditioner
package cic_pkg;

    // sampling clock and the seven filter times, in nanoseconds
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned FT0_NS = 100;
    localparam int unsigned FT1_NS = 200;
    localparam int unsigned FT2_NS = 500;
    localparam int unsigned FT3_NS = 1000;
    localparam int unsigned FT4_NS = 2000;
    localparam int unsigned FT5_NS = 5000;
    localparam int unsigned FT6_NS = 10000;

    // a pulse must outlast (time - smallest time); that span in whole cycles
    localparam int unsigned THR_W = 8;
    localparam logic [THR_W-1:0] THR0 = THR_W'((FT0_NS - FT0_NS) / CLK_PERIOD_NS);
    localparam logic [THR_W-1:0] THR1 = THR_W'((FT1_NS - FT0_NS) / CLK_PERIOD_NS);
    localparam logic [THR_W-1:0] THR2 = THR_W'((FT2_NS - FT0_NS) / CLK_PERIOD_NS);
    localparam logic [THR_W-1:0] THR3 = THR_W'((FT3_NS - FT0_NS) / CLK_PERIOD_NS);
    localparam logic [THR_W-1:0] THR4 = THR_W'((FT4_NS - FT0_NS) / CLK_PERIOD_NS);
    localparam logic [THR_W-1:0] THR5 = THR_W'((FT5_NS - FT0_NS) / CLK_PERIOD_NS);
    localparam logic [THR_W-1:0] THR6 = THR_W'((FT6_NS - FT0_NS) / CLK_PERIOD_NS);

    // filter select codes
    localparam int unsigned FSEL_W = 3;
    localparam logic [FSEL_W-1:0] FSEL_RESET = 3'h0;
    localparam logic [FSEL_W-1:0] FSEL_MAX = 3'h6;

    // register map, byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PPR_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] ANGLE_OFS = 8'h0C;

    // control word fields
    localparam int unsigned CTRL_INVCLK_BIT = 0;
    localparam int unsigned CTRL_INVDIR_BIT = 1;
    localparam int unsigned CTRL_INVRST_BIT = 2;
    localparam int unsigned CTRL_ANGREF_BIT = 3;
    localparam int unsigned CTRL_FSEL_LSB = 4;

    // status word fields: conditioned levels, then polarity corrected raw levels
    localparam int unsigned STAT_COND_LSB = 0;
    localparam int unsigned STAT_RAW_LSB = 4;

    // angle counter
    localparam int unsigned ANG_W = 16;
    localparam logic [ANG_W-1:0] PPR_RESET = 16'h0168;

    // input lanes
    localparam int unsigned NPIN = 3;
    localparam int unsigned PIN_CLK = 0;
    localparam int unsigned PIN_DIR = 1;
    localparam int unsigned PIN_RST = 2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic angleRef;
        logic invRst;
        logic invDir;
        logic invClk;
        logic [FSEL_W-1:0] fsel;
    } ctrl_s;

    // filter select code to required run length in cycles
    function automatic logic [THR_W-1:0] filtThreshold(input logic [FSEL_W-1:0] sel);
        logic [THR_W-1:0] t;
        t = THR0;
        unique case (sel)
            3'h0: t = THR0;
            3'h1: t = THR1;
            3'h2: t = THR2;
            3'h3: t = THR3;
            3'h4: t = THR4;
            3'h5: t = THR5;
            3'h6: t = THR6;
            default: t = THR0;
        endcase
        return t;
    endfunction

endpackage

// ==== rtl/pulse_width_filter.sv ====
// minimum pulse width filter for one digital input lane
`timescale 1ns/1ps
module pulse_width_filter (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // lane
    input wire logic din,
    input wire logic [cic_pkg::THR_W-1:0] threshold,
    output logic dout
);

    logic [cic_pkg::THR_W-1:0] run_r;
    logic dout_r;

    assign dout = dout_r;

    // a change is adopted only after threshold+1 differing samples in a row;
    // any sample that agrees with the output restarts the run, so short spikes die
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_r <= '0;
            dout_r <= 1'b0;
        end else if (din == dout_r) begin
            run_r <= '0;
        end else if (run_r >= threshold) begin
            dout_r <= din;
            run_r <= '0;
        end else begin
            run_r <= run_r + 1'b1;
        end
    end

endmodule

// ==== rtl/counter_input_conditioner.sv ====
// counter input conditioner: polarity, deglitch and angle reference reset
//
// Function
// - optional inversion of the count clock input
// - optional inversion of the direction input
// - optional inversion of the external reset input
// - deglitch filter drops pulses up to filter time minus 0.1us
// - seven filter times, 0.1 to 10 us
// - pulses over time minus 0.1us always pass
// - reset default filter time 0.1 us, no filtering
// - angle-ref mode: reset event zeroes the angle
`timescale 1ns/1ps
module counter_input_conditioner (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register bus
    input wire cic_pkg::apb_req_s apbReq,
    output cic_pkg::apb_rsp_s apbRsp,
    // input pins from the pulse source
    input wire logic clkPin,
    input wire logic dirPin,
    input wire logic rstPin,
    // conditioned signals to the counter core
    output logic condClk,
    output logic condDir,
    output logic condRst,
    output logic angleZero,
    output logic [cic_pkg::ANG_W-1:0] angle
);

    // control and configuration state
    cic_pkg::ctrl_s ctrl_r;
    logic [cic_pkg::ANG_W-1:0] ppr_r;

    // polarity corrected raw lanes and their filtered versions
    logic [cic_pkg::NPIN-1:0] rawPins;
    logic [cic_pkg::NPIN-1:0] invMask;
    logic [cic_pkg::NPIN-1:0] polPins;
    logic [cic_pkg::NPIN-1:0] filtPins;
    logic [cic_pkg::THR_W-1:0] threshold;

    // edge detection on the conditioned lanes
    logic clkPrev_r;
    logic rstPrev_r;
    logic clkRise;
    logic rstRise;

    // angle accumulator
    logic [cic_pkg::ANG_W-1:0] angle_r;
    logic [cic_pkg::ANG_W-1:0] angle_nxt;
    logic angleZero_r;

    // bus answer registers
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // bus decode
    logic setupPhase;
    logic writeDone;
    logic addrHit;
    logic [31:0] readWord;
    logic [cic_pkg::FSEL_W-1:0] wrFsel;

    // ------------------------------------------------------------------
    // input polarity
    // ------------------------------------------------------------------

    assign rawPins[cic_pkg::PIN_CLK] = clkPin;
    assign rawPins[cic_pkg::PIN_DIR] = dirPin;
    assign rawPins[cic_pkg::PIN_RST] = rstPin;

    assign invMask[cic_pkg::PIN_CLK] = ctrl_r.invClk;
    assign invMask[cic_pkg::PIN_DIR] = ctrl_r.invDir;
    assign invMask[cic_pkg::PIN_RST] = ctrl_r.invRst;

    // inversion ahead of filter
    // inverting first means the filter always judges the level the core sees,
    // so a polarity change never changes which pulses survive
    assign polPins = rawPins ^ invMask;

    // ------------------------------------------------------------------
    // deglitch filters
    // ------------------------------------------------------------------

    assign threshold = cic_pkg::filtThreshold(ctrl_r.fsel);

    for (genvar i = 0; i < cic_pkg::NPIN; i++) begin : gLane
        pulse_width_filter uFilt (
            .clock(clock),
            .rstn(rstn),
            .din(polPins[i]),
            .threshold(threshold),
            .dout(filtPins[i])
        );
    end

    // conditioned levels leave straight from the filter flip-flops
    assign condClk = filtPins[cic_pkg::PIN_CLK];
    assign condDir = filtPins[cic_pkg::PIN_DIR];
    assign condRst = filtPins[cic_pkg::PIN_RST];

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------

    // previous conditioned levels; the reset level after power-up is low,
    // matching the filter outputs, so no false edge appears at release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clkPrev_r <= 1'b0;
            rstPrev_r <= 1'b0;
        end else begin
            clkPrev_r <= filtPins[cic_pkg::PIN_CLK];
            rstPrev_r <= filtPins[cic_pkg::PIN_RST];
        end
    end

    assign clkRise = filtPins[cic_pkg::PIN_CLK] & ~clkPrev_r;
    assign rstRise = filtPins[cic_pkg::PIN_RST] & ~rstPrev_r;

    // ------------------------------------------------------------------
    // angle accumulator
    // ------------------------------------------------------------------

    // next angle: wraps within 0 .. ppr-1, direction high counts up
    always_comb begin
        angle_nxt = angle_r;
        if (ppr_r == '0) begin
            // no rotation defined, the angle stays at zero
            angle_nxt = '0;
        end else if (clkRise) begin
            if (filtPins[cic_pkg::PIN_DIR]) begin
                if (angle_r >= ppr_r - 1'b1) begin
                    angle_nxt = '0;
                end else begin
                    angle_nxt = angle_r + 1'b1;
                end
            end else begin
                if (angle_r == '0 || angle_r >= ppr_r) begin
                    angle_nxt = ppr_r - 1'b1;
                end else begin
                    angle_nxt = angle_r - 1'b1;
                end
            end
        end
        // reset event zeroes angle
        // the reference wins over a count edge in the same cycle
        if (ctrl_r.angleRef && rstRise) begin
            angle_nxt = '0;
        end
    end

    // angle register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            angle_r <= '0;
        end else begin
            angle_r <= angle_nxt;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            angleZero_r <= 1'b0;
        end else begin
            angleZero_r <= ctrl_r.angleRef & rstRise;
        end
    end

    assign angle = angle_r;
    assign angleZero = angleZero_r;

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign writeDone = apbReq.psel & apbReq.penable & pready_r & apbReq.pwrite;

    assign addrHit = (apbReq.paddr == cic_pkg::CTRL_OFS)
                   | (apbReq.paddr == cic_pkg::STATUS_OFS)
                   | (apbReq.paddr == cic_pkg::PPR_OFS)
                   | (apbReq.paddr == cic_pkg::ANGLE_OFS);

    assign wrFsel = apbReq.pwdata[cic_pkg::CTRL_FSEL_LSB +: cic_pkg::FSEL_W];

    // read mux; unused bits read as zero
    always_comb begin
        readWord = '0;
        unique case (apbReq.paddr)
            cic_pkg::CTRL_OFS: begin
                readWord[cic_pkg::CTRL_INVCLK_BIT] = ctrl_r.invClk;
                readWord[cic_pkg::CTRL_INVDIR_BIT] = ctrl_r.invDir;
                readWord[cic_pkg::CTRL_INVRST_BIT] = ctrl_r.invRst;
                readWord[cic_pkg::CTRL_ANGREF_BIT] = ctrl_r.angleRef;
                readWord[cic_pkg::CTRL_FSEL_LSB +: cic_pkg::FSEL_W] = ctrl_r.fsel;
            end
            cic_pkg::STATUS_OFS: begin
                readWord[cic_pkg::STAT_COND_LSB +: cic_pkg::NPIN] = filtPins;
                readWord[cic_pkg::STAT_RAW_LSB +: cic_pkg::NPIN] = polPins;
            end
            cic_pkg::PPR_OFS: begin
                readWord[cic_pkg::ANG_W-1:0] = ppr_r;
            end
            cic_pkg::ANGLE_OFS: begin
                readWord[cic_pkg::ANG_W-1:0] = angle_r;
            end
            default: begin
                readWord = '0;
            end
        endcase
    end

    // answer is prepared in the setup cycle, so every access phase ends
    // after one cycle and all answer signals come from flip-flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setupPhase;
            if (setupPhase) begin
                pslverr_r <= ~addrHit;
                prdata_r <= apbReq.pwrite ? 32'h00000000 : readWord;
            end else begin
                pslverr_r <= 1'b0;
                prdata_r <= '0;
            end
        end
    end

    assign apbRsp.pready = pready_r;
    assign apbRsp.pslverr = pslverr_r;
    assign apbRsp.prdata = prdata_r;

    // control register; an out of range filter code leaves the old choice
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r.invClk <= 1'b0;
            ctrl_r.invDir <= 1'b0;
            ctrl_r.invRst <= 1'b0;
            ctrl_r.angleRef <= 1'b0;
            ctrl_r.fsel <= cic_pkg::FSEL_RESET;
        end else if (writeDone && apbReq.paddr == cic_pkg::CTRL_OFS) begin
            ctrl_r.invClk <= apbReq.pwdata[cic_pkg::CTRL_INVCLK_BIT];
            ctrl_r.invDir <= apbReq.pwdata[cic_pkg::CTRL_INVDIR_BIT];
            ctrl_r.invRst <= apbReq.pwdata[cic_pkg::CTRL_INVRST_BIT];
            ctrl_r.angleRef <= apbReq.pwdata[cic_pkg::CTRL_ANGREF_BIT];
            if (wrFsel <= cic_pkg::FSEL_MAX) begin
                ctrl_r.fsel <= wrFsel;
            end
        end
    end

    // pulses per rotation; a new value takes effect at the next count edge, except zero, which clears the angle at once
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ppr_r <= cic_pkg::PPR_RESET;
        end else if (writeDone && apbReq.paddr == cic_pkg::PPR_OFS) begin
            ppr_r <= apbReq.pwdata[cic_pkg::ANG_W-1:0];
        end
    end

endmodule

// ==== verif/cic_properties.sv ====
// concurrent checks on the counter input conditioner ports
`timescale 1ns/1ps
module cic_properties (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register bus
    input wire cic_pkg::apb_req_s apbReq,
    input wire cic_pkg::apb_rsp_s apbRsp,
    // pins and conditioned outputs
    input wire logic clkPin,
    input wire logic dirPin,
    input wire logic rstPin,
    input wire logic condClk,
    input wire logic condDir,
    input wire logic condRst,
    input wire logic angleZero,
    input wire logic [cic_pkg::ANG_W-1:0] angle
);
    // (filter time - 0.1us) / 50ns, in samples
    localparam int THR [7] = '{0, 2, 8, 18, 38, 98, 198};
    logic [3:0] inv_r;
    logic [2:0] fsel_r;
    logic [7:0] run_r;
    logic ctrlWr;
    logic smp;
    logic [7:0] thr;
    assign ctrlWr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
        && apbReq.paddr == cic_pkg::CTRL_OFS;
    assign smp = clkPin ^ inv_r[0];
    assign thr = 8'(THR[fsel_r]);
    // shadow of the control word; code 7 is refused, so fsel keeps its value
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            inv_r <= 4'h0;
            fsel_r <= 3'h0;
        end else if (ctrlWr) begin
            inv_r <= apbReq.pwdata[3:0];
            if (apbReq.pwdata[6:4] != 3'h7) begin
                fsel_r <= apbReq.pwdata[6:4];
            end
        end
    end
    // run of clock lane samples that disagree with the output
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_r <= 8'h00;
        end else begin
            // a run that reaches the threshold is adopted and starts over
            run_r <= (smp != condClk && run_r < thr) ? run_r + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("pready stood longer than one cycle");
    a_ready_after_setup: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
        else $error("no answer in the access phase");
    a_unmapped_err: assert property (apbRsp.pready && !(apbReq.paddr inside {8'h00, 8'h04,
        8'h08, 8'h0C}) |-> apbRsp.pslverr && apbRsp.prdata == 32'h0)
        else $error("unmapped address not refused");
    a_write_rdata_zero: assert property (apbRsp.pready && apbReq.pwrite |-> apbRsp.prdata == 32'h0)
        else $error("read data on a write");
    a_clk_follow: assert property (fsel_r == 3'h0 |=> condClk == $past(smp))
        else $error("clock lane wrong at shortest filter");
    a_dir_follow: assert property (fsel_r == 3'h0 |=> condDir == $past(dirPin ^ inv_r[1]))
        else $error("direction lane wrong at shortest filter");
    a_rst_follow: assert property (fsel_r == 3'h0 |=> condRst == $past(rstPin ^ inv_r[2]))
        else $error("reset lane wrong at shortest filter");
    a_filter_pass: assert property (smp != condClk && run_r >= thr |=> condClk == $past(smp))
        else $error("wide pulse not passed");
    a_filter_drop: assert property (smp != condClk && run_r < thr |=> $stable(condClk))
        else $error("short pulse passed");
    a_angle_zero: assert property (inv_r[3] && $rose(condRst) |=> angle == 16'h0 && angleZero)
        else $error("reference event did not zero the angle");
    a_zero_cause: assert property ($rose(angleZero) |-> $past(inv_r[3]) && $past(condRst)
        && !$past(condRst, 2))
        else $error("angle zeroed without a reference event");
    c_zeroed: cover property (angleZero);
    c_refused: cover property (apbRsp.pready && apbRsp.pslverr);
    c_long_pass: cover property (smp != condClk && run_r == thr && thr > 8'h02);
endmodule

// ==== verif/pulse_source.sv ====
// behavioural pulse source standing in for an encoder or switch
`timescale 1ns/1ps
module pulse_source (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // pulse request
    input wire logic go,
    input wire logic [1:0] lane,
    input wire logic [7:0] width,
    input wire logic [2:0] idle,
    // source pins
    output logic [2:0] pins,
    output logic busy
);
    logic [7:0] left_r;
    logic [1:0] lane_r;
    // count out the pulse; a new request restarts it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            left_r <= 8'h00;
            lane_r <= 2'h0;
        end else if (go) begin
            left_r <= width;
            lane_r <= lane;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    // push-pull drivers, so the level between pulses is always defined
    assign busy = (left_r != 8'h00);
    assign pins = idle ^ (busy ? (3'h1 << lane_r) : 3'h0);
endmodule

// ==== verif/test_counter_input_conditioner.sv ====
// self-checking bench for the counter input conditioner
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checkCount++; if ((got) !== (exp)) begin errTotal++; \
    $display("BAD %0t %s", $time, msg); end end
module test_counter_input_conditioner;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    cic_pkg::apb_req_s apbReq = '0;
    cic_pkg::apb_rsp_s apbRsp;
    logic [2:0] pins;
    logic condClk, condDir, condRst, angleZero, srcBusy;
    logic [15:0] angle;
    logic go = 1'b0;
    logic [1:0] lane = 2'h0;
    logic [7:0] width = 8'h00;
    logic [2:0] idle = 3'h2; // direction held high so the angle counts up
    logic [32:0] expQ[$];
    logic [32:0] note;
    logic [31:0] seed = 32'h0000_0050;
    int errTotal = 0;
    int checkCount = 0;
    always #25 clock = ~clock;
    counter_input_conditioner i_counter_input_conditioner (.clock(clock), .rstn(rstn),
        .apbReq(apbReq), .apbRsp(apbRsp), .clkPin(pins[0]), .dirPin(pins[1]), .rstPin(pins[2]),
        .condClk(condClk), .condDir(condDir), .condRst(condRst), .angleZero(angleZero),
        .angle(angle));
    pulse_source i_pulse_source (.clock(clock), .rstn(rstn), .go(go), .lane(lane),
        .width(width), .idle(idle), .pins(pins), .busy(srcBusy));
    task automatic printVerdict();
        if (errTotal == 0 && checkCount > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // scoreboard: every bus answer retires the oldest note
    always @(posedge clock) begin
        if (rstn && apbRsp.pready === 1'b1) begin
            note = expQ.pop_front();
            `CHK(apbRsp.pslverr, note[32], "pslverr")
            `CHK(apbRsp.prdata, note[31:0], "prdata")
        end
    end
    // one bus transfer; the request is held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] er, input logic ee);
        int n;
        expQ.push_back({ee, er});
        @(posedge clock);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (apbRsp.pready !== 1'b1 && n < 40);
        if (apbRsp.pready !== 1'b1) begin errTotal++; printVerdict(); end
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // one pulse of w samples on a lane, then time for the filter to settle
    task automatic pulse(input logic [1:0] l, input logic [7:0] w, input int settle);
        int n;
        @(posedge clock);
        go <= 1'b1;
        lane <= l;
        width <= w;
        @(posedge clock);
        go <= 1'b0;
        // the source loads its count at this edge; busy is seen one edge later
        @(posedge clock);
        n = 0;
        while (srcBusy === 1'b1 && n < 300) begin @(posedge clock); n++; end
        if (n >= 300) begin errTotal++; printVerdict(); end
        repeat (settle) @(posedge clock);
    endtask
    // main sequence
    initial begin
        logic [7:0] tbl [7] = '{8'h00, 8'h02, 8'h08, 8'h12, 8'h26, 8'h62, 8'hC6};
        logic [15:0] expAngle;
        logic [7:0] w;
        int t;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, cic_pkg::CTRL_OFS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, cic_pkg::PPR_OFS, 32'h0, 32'h168, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        apb(1'b1, cic_pkg::STATUS_OFS, 32'hFF, 32'h0, 1'b0);
        apb(1'b0, cic_pkg::STATUS_OFS, 32'h0, 32'h22, 1'b0);
        // all three lanes inverted ahead of the filter
        apb(1'b1, cic_pkg::CTRL_OFS, 32'h07, 32'h0, 1'b0);
        repeat (3) @(posedge clock);
        apb(1'b0, cic_pkg::STATUS_OFS, 32'h0, 32'h55, 1'b0);
        apb(1'b1, cic_pkg::CTRL_OFS, 32'h08, 32'h0, 1'b0);
        pulse(2'h2, 8'h01, 4);
        apb(1'b0, cic_pkg::ANGLE_OFS, 32'h0, 32'h0, 1'b0);
        expAngle = 16'h0;
        // every filter time: drop at T samples, pass at T+1, then one random width
        for (int f = 0; f < 7; f++) begin
            t = tbl[f];
            apb(1'b1, cic_pkg::CTRL_OFS, 32'h08 | (f << 4), 32'h0, 1'b0);
            pulse(2'h0, 8'(t), t + 4);
            pulse(2'h0, 8'(t + 1), t + 4);
            w = 8'(1 + xs() % (t + t / 4 + 2));
            pulse(2'h0, w, t + 4);
            expAngle = expAngle + 16'h1 + ((w > t) ? 16'h1 : 16'h0);
            apb(1'b0, cic_pkg::ANGLE_OFS, 32'h0, {16'h0, expAngle}, 1'b0);
        end
        // code 7 refused, other bits still land
        apb(1'b1, cic_pkg::CTRL_OFS, 32'h70, 32'h0, 1'b0);
        apb(1'b0, cic_pkg::CTRL_OFS, 32'h0, 32'h60, 1'b0);
        pulse(2'h2, 8'hC7, 204);
        apb(1'b0, cic_pkg::ANGLE_OFS, 32'h0, {16'h0, expAngle}, 1'b0);
        apb(1'b1, cic_pkg::CTRL_OFS, 32'h68, 32'h0, 1'b0);
        pulse(2'h2, 8'hC7, 204);
        apb(1'b0, cic_pkg::ANGLE_OFS, 32'h0, 32'h0, 1'b0);
        apb(1'b1, cic_pkg::PPR_OFS, 32'h5, 32'h0, 1'b0);
        apb(1'b0, cic_pkg::PPR_OFS, 32'h0, 32'h5, 1'b0);
        printVerdict();
    end
endmodule
bind counter_input_conditioner cic_properties i_cic_properties (.clock(clock), .rstn(rstn),
    .apbReq(apbReq), .apbRsp(apbRsp), .clkPin(clkPin), .dirPin(dirPin), .rstPin(rstPin),
    .condClk(condClk), .condDir(condDir), .condRst(condRst), .angleZero(angleZero),
    .angle(angle));
